// ==== design/uart_tx_fifo_threshold_irq.sv ====
// transmit fifo, empty-space tracking, holding-register-empty interrupt,
// dma request and 16x baud tick for one uart channel
// assumes host strobes and shift_load are one-cycle pulses on clk_sys
//
// How it works
// - threshold enabled and empty spaces reach threshold: raise interrupt
// - after threshold interrupt, two host writes needed before another
// - dma request (active low) asserts when empty spaces exceed threshold
// - dma request holds until the fifo is completely full
// - threshold interrupt stays pending until holding write or ident read
// - ident read without data write drops the interrupt output
// - after ident read and no write, draining empty raises nothing
// - one host write services the interrupt and clears the flag
// - after service, fifo draining to empty raises the interrupt again
// - fifo reset raises the holding-register-empty interrupt
// - baud tick is 1/16 of a bit: sixteen ticks per bit
`timescale 1ns/100ps
`default_nettype none

module uart_tx_fifo_threshold_irq (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // host strobes and configuration
  input wire uart_txlvl_pkg::host_req_type host,
  input wire uart_txlvl_pkg::tx_cfg_type cfg,
  // transmitter shift register side
  input wire logic shift_load,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  // status and requests
  output logic [6:0] empty_spaces,
  output logic irq_out,
  output logic tx_dma_request_n,
  // timing
  output logic baud_tick,
  output logic bit_tick
);
  import uart_txlvl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // fifo storage and space count

  logic [7:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
  logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
  logic [CNT_W-1:0] spaces_r, spaces_nxt;
  logic [7:0] tx_char_r, tx_char_nxt;
  logic tx_char_valid_r, tx_char_valid_nxt;
  logic wr_ok, pop_ok, empty_now;

  always_comb begin
    // writes to a full fifo and pops from an empty one are dropped
    wr_ok = host.wr & (spaces_r != SPACES_NONE);
    pop_ok = shift_load & (spaces_r != SPACES_ALL);
    empty_now = (spaces_r == SPACES_ALL);
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    spaces_nxt = spaces_r;
    tx_char_nxt = tx_char_r;
    tx_char_valid_nxt = 1'b0;
    if (host.fifo_rst) begin
      wr_ptr_nxt = PTR_RST;
      rd_ptr_nxt = PTR_RST;
      spaces_nxt = SPACES_ALL;
    end else begin
      if (wr_ok) begin
        wr_ptr_nxt = PTR_W'(wr_ptr_r + 6'h01);
      end
      if (pop_ok) begin
        rd_ptr_nxt = PTR_W'(rd_ptr_r + 6'h01);
        tx_char_nxt = mem[rd_ptr_r];
        tx_char_valid_nxt = 1'b1;
      end
      spaces_nxt = CNT_W'(spaces_r - {6'h00, wr_ok} + {6'h00, pop_ok});
    end
  end

  // storage needs no reset; pointers define what is valid
  always_ff @(posedge clk_sys) begin
    if (wr_ok && !host.fifo_rst) begin
      mem[wr_ptr_r] <= host.wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= PTR_RST;
      rd_ptr_r <= PTR_RST;
      spaces_r <= SPACES_ALL;
      tx_char_r <= CHAR_RST;
      tx_char_valid_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      spaces_r <= spaces_nxt;
      tx_char_r <= tx_char_nxt;
      tx_char_valid_r <= tx_char_valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // holding-register-empty interrupt service tracking

  svc_state_type st_r, st_nxt;
  logic irq_r, irq_nxt;
  logic [1:0] wcnt_r, wcnt_nxt;
  logic was_empty_r;

  always_comb begin
    st_nxt = st_r;
    irq_nxt = irq_r;
    wcnt_nxt = wcnt_r;
    if (host.fifo_rst) begin
      irq_nxt = 1'b1;
      st_nxt = ST_RAISED;
      wcnt_nxt = WCNT_RST;
    end else if (!cfg.thr_en) begin
      // conventional mode; a new empty edge beats a same-cycle clear
      st_nxt = ST_ARMED;
      wcnt_nxt = WCNT_RST;
      if (wr_ok || host.iir_rd) begin
        irq_nxt = 1'b0;
      end
      if (empty_now && !was_empty_r) begin
        irq_nxt = 1'b1;
      end
    end else begin
      unique case (st_r)
        ST_ARMED: begin
          if (spaces_r >= cfg.tx_holding_reg) begin
            irq_nxt = 1'b1;
            st_nxt = ST_RAISED;
          end
        end
        ST_RAISED: begin
          if (wr_ok) begin
            irq_nxt = 1'b0;
            wcnt_nxt = 2'h1;
            st_nxt = ST_SERVICED;
          end else if (host.iir_rd) begin
            irq_nxt = 1'b0;
            st_nxt = ST_ACKED;
          end
          // otherwise held pending
        end
        ST_ACKED: begin
          // empty fifo is ignored here: service incomplete
          if (wr_ok) begin
            wcnt_nxt = 2'h1;
            st_nxt = ST_SERVICED;
          end
        end
        ST_SERVICED: begin
          if (empty_now) begin
            irq_nxt = 1'b1;
            wcnt_nxt = WCNT_RST;
            st_nxt = ST_RAISED;
          end else if (wr_ok) begin
            if (2'(wcnt_r + 2'h1) == HYST_WRITES) begin
              wcnt_nxt = WCNT_RST;
              st_nxt = ST_ARMED;
            end else begin
              wcnt_nxt = 2'(wcnt_r + 2'h1);
            end
          end
        end
        default: begin
          st_nxt = ST_ARMED;
          wcnt_nxt = WCNT_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= ST_ARMED;
      irq_r <= IRQ_RST;
      wcnt_r <= WCNT_RST;
      was_empty_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      irq_r <= irq_nxt;
      wcnt_r <= wcnt_nxt;
      was_empty_r <= empty_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dma request: set above threshold, released only on full

  logic dma_n_r, dma_n_nxt;

  always_comb begin
    dma_n_nxt = dma_n_r;
    if (spaces_r > cfg.tx_holding_reg) begin
      dma_n_nxt = 1'b0;
    end else if (spaces_r == SPACES_NONE) begin
      dma_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_n_r <= DMA_N_RST;
    end else begin
      dma_n_r <= dma_n_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // baud divider: 16x tick, and a bit tick every sixteenth one

  logic [15:0] div_cnt_r, div_cnt_nxt;
  logic [3:0] sub_r, sub_nxt;
  logic baud_r, baud_nxt;
  logic bit_r, bit_nxt;

  always_comb begin
    div_cnt_nxt = div_cnt_r;
    sub_nxt = sub_r;
    baud_nxt = 1'b0;
    bit_nxt = 1'b0;
    // divisor zero stops the generator rather than ticking every cycle
    if (cfg.divisor != 16'h0000) begin
      if (16'(div_cnt_r + 16'h0001) >= cfg.divisor) begin
        div_cnt_nxt = DIV_CNT_RST;
        baud_nxt = 1'b1;
        sub_nxt = 4'(sub_r + 4'h1);
        bit_nxt = (sub_r == TICKS_PER_BIT_LAST);
      end else begin
        div_cnt_nxt = 16'(div_cnt_r + 16'h0001);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt_r <= DIV_CNT_RST;
      sub_r <= SUB_RST;
      baud_r <= 1'b0;
      bit_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      sub_r <= sub_nxt;
      baud_r <= baud_nxt;
      bit_r <= bit_nxt;
    end
  end

  assign tx_char = tx_char_r;
  assign tx_char_valid = tx_char_valid_r;
  assign empty_spaces = spaces_r;
  assign irq_out = irq_r;
  assign tx_dma_request_n = dma_n_r;
  assign baud_tick = baud_r;
  assign bit_tick = bit_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_thr_raise;
    cfg.thr_en && st_r == ST_ARMED && spaces_r >= cfg.tx_holding_reg |=> irq_out;
  endproperty
  a_thr_raise: assert property (p_thr_raise)
    else $error("threshold reached but interrupt not raised");

  property p_hyst;
    cfg.thr_en && st_r == ST_SERVICED && !empty_now && !host.fifo_rst
      |=> !irq_out;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("interrupt raised inside hysteresis window");

  property p_dma_set;
    spaces_r > cfg.tx_holding_reg |=> !tx_dma_request_n;
  endproperty
  a_dma_set: assert property (p_dma_set)
    else $error("dma request missing above threshold");

  property p_dma_hold;
    !tx_dma_request_n && spaces_r != SPACES_NONE
      |=> !tx_dma_request_n;
  endproperty
  a_dma_hold: assert property (p_dma_hold)
    else $error("dma request dropped before fifo full");

  property p_pending;
    cfg.thr_en && irq_out && st_r == ST_RAISED && !wr_ok && !host.iir_rd
      && !host.fifo_rst |=> irq_out && st_r == ST_RAISED;
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending interrupt lost without service");

  property p_ident_clear;
    cfg.thr_en && st_r == ST_RAISED && host.iir_rd && !wr_ok
      && !host.fifo_rst ##1 cfg.thr_en && !host.fifo_rst
      |-> !irq_out ##1 !irq_out;
  endproperty
  a_ident_clear: assert property (p_ident_clear)
    else $error("ident read did not drop interrupt");

  property p_acked_quiet;
    cfg.thr_en && st_r == ST_ACKED && !host.fifo_rst |=> !irq_out;
  endproperty
  a_acked_quiet: assert property (p_acked_quiet)
    else $error("interrupt raised while service incomplete");

  property p_write_service;
    cfg.thr_en && st_r == ST_RAISED && wr_ok && !host.fifo_rst
      |=> !irq_out && st_r == ST_SERVICED;
  endproperty
  a_write_service: assert property (p_write_service)
    else $error("write did not service interrupt");

  property p_drain_raise;
    cfg.thr_en && st_r == ST_SERVICED && empty_now |=> irq_out;
  endproperty
  a_drain_raise: assert property (p_drain_raise)
    else $error("drain to empty did not raise interrupt");

  property p_fifo_rst;
    host.fifo_rst |=> irq_out && empty_spaces == SPACES_ALL;
  endproperty
  a_fifo_rst: assert property (p_fifo_rst)
    else $error("fifo reset did not raise interrupt");

  property p_bit_tick;
    bit_tick |-> baud_tick && sub_r == SUB_RST && $past(sub_r) == 4'hF;
  endproperty
  a_bit_tick: assert property (p_bit_tick)
    else $error("bit tick not on sixteenth baud tick");

  property p_space_count;
    wr_ok && !pop_ok && !host.fifo_rst
      |=> empty_spaces == 7'($past(empty_spaces) - 7'h01);
  endproperty
  a_space_count: assert property (p_space_count)
    else $error("space count not reduced by write");

  property p_plain_empty;
    !cfg.thr_en && !host.fifo_rst && empty_now && !was_empty_r |=> irq_out;
  endproperty
  a_plain_empty: assert property (p_plain_empty)
    else $error("fifo empty did not raise interrupt");

  c_thr_serviced: cover property (irq_out && st_r == ST_RAISED ##1
    st_r == ST_SERVICED ##[1:200] st_r == ST_ARMED);
  c_ident_path: cover property (st_r == ST_RAISED ##1 st_r == ST_ACKED);
  c_dma_full: cover property (!tx_dma_request_n ##1 tx_dma_request_n);
  c_drain_again: cover property (st_r == ST_SERVICED && empty_now);

endmodule

`default_nettype wire

// ==== design/uart_txlvl_pkg.sv ====
// transmit fifo level logic: shared constants, states and carriers
// assumes a single 125 MHz clock and same-clock host and transmitter logic
`default_nettype none

package uart_txlvl_pkg;

  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;

  // empty-space count: all free after reset, none when full
  localparam logic [CNT_W-1:0] SPACES_ALL = 7'h40;
  localparam logic [CNT_W-1:0] SPACES_NONE = 7'h00;

  // writes needed after a threshold interrupt before it may fire again
  localparam logic [1:0] HYST_WRITES = 2'h2;

  // baud tick is 1/16 of a bit: sub-count wraps after 16 ticks
  localparam logic [3:0] TICKS_PER_BIT_LAST = 4'hF;

  // reset values
  localparam logic IRQ_RST = 1'b0;
  localparam logic DMA_N_RST = 1'b1;
  localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
  localparam logic [15:0] DIV_CNT_RST = 16'h0000;
  localparam logic [3:0] SUB_RST = 4'h0;
  localparam logic [1:0] WCNT_RST = 2'h0;
  localparam logic [7:0] CHAR_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_ARMED = 4'h1,
    ST_RAISED = 4'h2,
    ST_ACKED = 4'h4,
    ST_SERVICED = 4'h8
  } svc_state_type;

  // one-cycle strobes from the host bus decoder
  typedef struct packed {
    logic wr;
    logic [7:0] wr_data;
    logic iir_rd;
    logic fifo_rst;
  } host_req_type;

  // static configuration levels
  typedef struct packed {
    logic thr_en;
    logic [CNT_W-1:0] tx_holding_reg;
    logic [15:0] divisor;
  } tx_cfg_type;

endpackage

`default_nettype wire

// ==== sim/uart_tx_drain_model.sv ====
// transmitter model: pops characters from the tx fifo by shift_load
// assumes same clock as the fifo; gap sets slow or prompt service
`timescale 1ns/100ps
`default_nettype none

module uart_tx_drain_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic en,
  input wire logic [1:0] gap,
  // fifo side
  input wire logic [6:0] empty_spaces,
  output logic shift_load
);
  logic [1:0] wait_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_r <= 2'h0;
      shift_load <= 1'b0;
    end else if (en && empty_spaces != 7'h40 && wait_r == 2'h0) begin
      // stale count may cost one refused pop at the tail; harmless
      shift_load <= 1'b1;
      wait_r <= gap;
    end else begin
      shift_load <= 1'b0;
      if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ==== sim/uart_tx_fifo_threshold_irq_bench.sv ====
// testbench for the tx fifo level, interrupt, dma request and baud tick
// assumes the drain model stands in for the transmitter
`timescale 1ns/100ps
`default_nettype none

module uart_tx_fifo_threshold_irq_bench;
  import uart_txlvl_pkg::*;

  logic clk_sys, rst, shift_load, tx_char_valid, irq_out, drain_en;
  logic tx_dma_request_n, baud_tick, bit_tick;
  logic [7:0] tx_char;
  logic [6:0] empty_spaces;
  logic [1:0] drain_gap;
  host_req_type host;
  tx_cfg_type cfg;
  logic [7:0] exp_q[$];
  int fails = 0;
  int total_checks = 0;
  int bt = 0;

  uart_tx_fifo_threshold_irq i_uart_tx_fifo_threshold_irq (
    .clk_sys(clk_sys), .rst(rst), .host(host), .cfg(cfg),
    .shift_load(shift_load), .tx_char(tx_char),
    .tx_char_valid(tx_char_valid), .empty_spaces(empty_spaces),
    .irq_out(irq_out), .tx_dma_request_n(tx_dma_request_n),
    .baud_tick(baud_tick), .bit_tick(bit_tick));

  uart_tx_drain_model i_uart_tx_drain_model (
    .clk_sys(clk_sys), .rst(rst), .en(drain_en), .gap(drain_gap),
    .empty_spaces(empty_spaces), .shift_load(shift_load));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // strobe held high across back-to-back writes
  task automatic wr(input int n);
    host.wr = 1'b1;
    repeat (n) begin
      host.wr_data = 8'($urandom);
      if (exp_q.size() < FIFO_DEPTH) exp_q.push_back(host.wr_data);
      cyc(1);
    end
    host.wr = 1'b0;
  endtask

  task automatic rd();
    host.iir_rd = 1'b1;
    cyc(1);
    host.iir_rd = 1'b0;
  endtask

  task automatic wait_empty();
    int i;
    for (i = 0; i < 2000 && empty_spaces !== SPACES_ALL; i++) cyc(1);
    chk(8'(i < 2000), 8'h01);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // popped characters must come out in write order
  always @(posedge clk_sys) begin
    #2;
    if (tx_char_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("FAIL %0t character without a write", $time);
      end else begin
        chk(tx_char, exp_q.pop_front());
      end
    end
  end

  always @(posedge clk_sys) begin
    #2;
    if (rst) begin
      bt = 0;
    end else begin
      if (baud_tick === 1'b1) bt++;
      if (bit_tick === 1'b1) begin
        chk(8'(bt), 8'h10);
        bt = 0;
      end
    end
  end

  initial begin
    cyc(20000);
    fails++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    host = '0;
    cfg = '{thr_en: 1'b1, tx_holding_reg: 7'h08, divisor: 16'h0003};
    drain_en = 1'b0;
    drain_gap = 2'h0;
    void'($urandom(32'h2ffa7e51));
    repeat (20) @(posedge clk_sys);
    #1;
    chk(8'(irq_out), 8'h00);
    chk(8'(tx_dma_request_n), 8'h01);
    chk({1'b0, empty_spaces}, 8'h40);
    rst = 1'b0;
    cyc(3);
    chk(8'(irq_out), 8'h01);
    chk(8'(tx_dma_request_n), 8'h00);
    cyc(10);
    chk(8'(irq_out), 8'h01);
    rd();
    cyc(2);
    chk(8'(irq_out), 8'h00);
    cyc(20);
    chk(8'(irq_out), 8'h00);
    wr(1);
    cyc(2);
    chk({1'b0, empty_spaces}, 8'h3F);
    drain_gap = 2'($urandom_range(3, 0));
    drain_en = 1'b1;
    wait_empty();
    drain_en = 1'b0;
    cyc(3);
    chk(8'(irq_out), 8'h01);
    wr(1);
    cyc(3);
    chk(8'(irq_out), 8'h00);
    cyc(5);
    chk(8'(irq_out), 8'h00);
    wr(1);
    cyc(3);
    chk(8'(irq_out), 8'h01);
    wr(61);
    cyc(3);
    chk(8'(tx_dma_request_n), 8'h00);
    wr(1);
    cyc(3);
    chk(8'(tx_dma_request_n), 8'h01);
    chk({1'b0, empty_spaces}, 8'h00);
    wr(1);
    cyc(2);
    chk({1'b0, empty_spaces}, 8'h00);
    drain_gap = 2'($urandom_range(3, 0));
    drain_en = 1'b1;
    wait_empty();
    drain_en = 1'b0;
    cyc(3);
    chk(8'(exp_q.size()), 8'h00);
    chk(8'(tx_dma_request_n), 8'h00);
    rd();
    cyc(3);
    chk(8'(irq_out), 8'h00);
    host.fifo_rst = 1'b1;
    cyc(1);
    host.fifo_rst = 1'b0;
    cyc(2);
    chk(8'(irq_out), 8'h01);
    chk({1'b0, empty_spaces}, 8'h40);
    cfg.thr_en = 1'b0;
    rd();
    cyc(3);
    chk(8'(irq_out), 8'h00);
    wr(1);
    drain_en = 1'b1;
    wait_empty();
    cyc(3);
    chk(8'(irq_out), 8'h01);
    // divisor zero must stop the tick generator
    cfg.divisor = 16'h0000;
    repeat (40) begin
      cyc(1);
      chk(8'(baud_tick), 8'h00);
    end
    cyc(100);
    conclude();
  end
endmodule

`default_nettype wire
